// ==== shared/rscl_pkg.sv ====
// Constants, types and encodings for the reset strap configuration latch
package rscl_pkg;

   // Uplink interface encodings of the two-bit interface strap
   typedef enum logic [1:0] {
      RSCL_IF_MII = 2'b00,
      RSCL_IF_RMII = 2'b01,
      RSCL_IF_GMII = 2'b10,
      RSCL_IF_RGMII = 2'b11
   } rscl_iface_e;

   // Latch state
   typedef enum logic [1:0] {
      RSCL_ST_SAMPLE = 2'b00,
      RSCL_ST_RUN = 2'b01
   } rscl_state_e;

   // Strap bit positions in the sampled vector
   localparam int RSCL_BIT_REFCLK = 0;
   localparam int RSCL_BIT_ROLE = 1;
   localparam int RSCL_BIT_IF_LO = 2;
   localparam int RSCL_BIT_IF_HI = 3;
   localparam int RSCL_BIT_SPEED = 4;
   localparam int RSCL_BIT_PLL = 5;
   localparam int RSCL_BIT_SERIAL = 6;
   localparam int RSCL_STRAP_W = 7;

   // Pull defaults: serial strap has no internal default, pulled low
   localparam logic [6:0] RSCL_STRAP_RST = 7'h3F;

   // Cycles after reset release before straps are captured (sync depth plus one)
   localparam logic [1:0] RSCL_CAPTURE_CYCLES = 2'h3;

   // Software RMII clock select register and bit
   localparam logic [7:0] RSCL_RMII_CTL_OFFSET = 8'h56;
   localparam int RSCL_RMII_CTL_BIT = 7;

   // LED mode field of the global control register
   localparam int RSCL_LED_MODE_LSB = 4;
   localparam int RSCL_LED_MODE_MSB = 5;
   localparam int RSCL_LED_PINS = 6;

   // Captured configuration
   typedef struct packed {
      logic refclk_en;
      logic mac_role;
      rscl_iface_e iface;
      logic gig_speed;
      logic pll_crystal;
      logic mdio_mode;
   } rscl_cfg_s;

   // Pin pair: output, output enable (low = driving)
   typedef struct packed {
      logic o;
      logic oe_n;
   } rscl_pin_s;

endpackage

// ==== hdl/rscl_latch.sv ====
// Reset strap capture, strap pin reuse and uplink configuration outputs
`timescale 1ns/1ns

// Functional notes
// - Sample every strap pin at reset
// - Strap pins input in reset, output after; serial data out pin only in SPI mode while selected
// - After reset pins drive LEDs per mode
// - Refclk strap high enables 25MHz output
// - Two-bit strap selects MII/RMII/GMII/RGMII
// - Role strap high MAC, low PHY
// - MII PHY role turns CRS/COL, clocks into outputs
// - RMII: high drives rx clock, low external
// - Software bit may override RMII clock choice
// - PLL strap picks crystal or external clock
// - Speed strap sets gigabit, software may change
// - Serial strap low SPI, high MDIO
// - Chip select high floats serial output
// - Data pin SPI input or MDIO bidirectional
// - Hardware reset clears logic, straps sampled
module rscl_latch import rscl_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Strap pins: pad level in, driven level out, enable (low drives)
   input wire logic refclk_enable_strap_pin_i,
   output logic refclk_enable_strap_pin_o,
   output logic refclk_enable_strap_pin_oe_n,
   input wire logic uplink_role_strap_pin_i,
   output logic uplink_role_strap_pin_o,
   output logic uplink_role_strap_pin_oe_n,
   input wire logic [1:0] uplink_iface_strap_pins_i,
   output logic [1:0] uplink_iface_strap_pins_o,
   output logic [1:0] uplink_iface_strap_pins_oe_n,
   input wire logic uplink_speed_strap_pin_i,
   output logic uplink_speed_strap_pin_o,
   output logic uplink_speed_strap_pin_oe_n,
   input wire logic pll_source_strap_pin_i,
   output logic pll_source_strap_pin_o,
   output logic pll_source_strap_pin_oe_n,
   input wire logic serial_data_out_i,
   output logic serial_data_out_o,
   output logic serial_data_out_oe_n,
   // Serial management pins
   input wire logic serial_chip_select_n,
   output logic serial_data_io_oe_n,
   // Port logic: LED sources, LED mode, serial drive requests
   input wire logic [5:0] led_src_a,
   input wire logic [5:0] led_src_b,
   input wire logic [1:0] led_mode,
   input wire logic spi_q_data,
   input wire logic mdio_drive,
   // Software overrides: write pulse with value
   input wire logic sw_rmii_clk_wr,
   input wire logic sw_rmii_clk_internal,
   input wire logic sw_speed_wr,
   input wire logic sw_speed_gig,
   // Configuration outputs
   output rscl_cfg_s cfg,
   output logic cfg_valid,
   output logic ref_clock_output_en,
   output logic rmii_clk_internal,
   output logic uplink_rx_clock_pin_oe_n,
   output logic uplink_tx_clock_pin_oe_n,
   output logic crs_col_oe_n,
   output logic pll_use_ext_clock,
   output logic uplink_gig_mac_1g
);

   logic [RSCL_STRAP_W-1:0] strap_meta_q;
   logic [RSCL_STRAP_W-1:0] strap_sync_q;
   logic cs_meta_q;
   logic cs_sync_q;
   logic [1:0] cap_cnt_q;
   rscl_state_e state_q;
   rscl_cfg_s cfg_q;
   logic rmii_int_q;
   logic gig_q;
   logic [RSCL_LED_PINS-1:0] led_q;
   logic sdo_q;
   logic sdo_oe_n_q;
   logic [RSCL_LED_PINS-1:0] led_sel;

   // LED status selected by mode field
   function automatic logic led_pick(input logic a, input logic b, input logic [1:0] m);
      case (m)
         2'b00: led_pick = a;
         2'b01: led_pick = b;
         2'b10: led_pick = a & b;
         default: led_pick = a | b;
      endcase
   endfunction

   // Pad synchronisers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_meta_q <= RSCL_STRAP_RST;
         strap_sync_q <= RSCL_STRAP_RST;
      end else begin
         strap_meta_q <= {serial_data_out_i, pll_source_strap_pin_i, uplink_speed_strap_pin_i,
                          uplink_iface_strap_pins_i, uplink_role_strap_pin_i, refclk_enable_strap_pin_i};
         strap_sync_q <= strap_meta_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
      end else begin
         cs_meta_q <= serial_chip_select_n;
         cs_sync_q <= cs_meta_q;
      end
   end

   // Capture sequencer: pins stay inputs until sampled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cap_cnt_q <= 2'h0;
         state_q <= RSCL_ST_SAMPLE;
      end else begin
         case (state_q)
            RSCL_ST_SAMPLE: begin
               if (cap_cnt_q == RSCL_CAPTURE_CYCLES - 2'h1) begin
                  state_q <= RSCL_ST_RUN;
               end
               cap_cnt_q <= cap_cnt_q + 2'h1;
            end
            default: begin
               state_q <= RSCL_ST_RUN;
            end
         endcase
      end
   end

   // Strap capture, held until next reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= '{1'b1, 1'b1, RSCL_IF_RGMII, 1'b1, 1'b1, 1'b0};
      end else if (state_q == RSCL_ST_SAMPLE && cap_cnt_q == RSCL_CAPTURE_CYCLES - 2'h1) begin
         cfg_q.refclk_en <= strap_sync_q[RSCL_BIT_REFCLK];
         cfg_q.mac_role <= strap_sync_q[RSCL_BIT_ROLE];
         cfg_q.iface <= rscl_iface_e'(strap_sync_q[RSCL_BIT_IF_HI:RSCL_BIT_IF_LO]);
         cfg_q.gig_speed <= strap_sync_q[RSCL_BIT_SPEED];
         cfg_q.pll_crystal <= strap_sync_q[RSCL_BIT_PLL];
         cfg_q.mdio_mode <= strap_sync_q[RSCL_BIT_SERIAL];
      end
   end

   // RMII clock choice: strap at capture, software write after
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rmii_int_q <= 1'b1;
      end else if (state_q == RSCL_ST_SAMPLE && cap_cnt_q == RSCL_CAPTURE_CYCLES - 2'h1) begin
         rmii_int_q <= strap_sync_q[RSCL_BIT_ROLE];
      end else if (state_q == RSCL_ST_RUN && sw_rmii_clk_wr) begin
         rmii_int_q <= sw_rmii_clk_internal;
      end
   end

   // Gigabit speed: strap at capture, software write after
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gig_q <= 1'b1;
      end else if (state_q == RSCL_ST_SAMPLE && cap_cnt_q == RSCL_CAPTURE_CYCLES - 2'h1) begin
         gig_q <= strap_sync_q[RSCL_BIT_SPEED];
      end else if (state_q == RSCL_ST_RUN && sw_speed_wr) begin
         gig_q <= sw_speed_gig;
      end
   end

   // LED drive after reset
   always_comb begin
      for (int i = 0; i < RSCL_LED_PINS; i++) begin
         led_sel[i] = led_pick(led_src_a[i], led_src_b[i], led_mode);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         led_q <= 6'h3F;
      end else if (state_q == RSCL_ST_RUN) begin
         led_q <= ~led_sel;
      end
   end

   // Serial output: SPI data while selected, float when deselected
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sdo_q <= 1'b0;
         sdo_oe_n_q <= 1'b1;
      end else begin
         sdo_q <= spi_q_data;
         sdo_oe_n_q <= !(state_q == RSCL_ST_RUN && !cfg_q.mdio_mode && !cs_sync_q);
      end
   end

   // Pin outputs
   assign refclk_enable_strap_pin_o = led_q[0];
   assign uplink_role_strap_pin_o = led_q[1];
   assign uplink_iface_strap_pins_o = led_q[3:2];
   assign uplink_speed_strap_pin_o = led_q[4];
   assign pll_source_strap_pin_o = led_q[5];
   assign refclk_enable_strap_pin_oe_n = (state_q != RSCL_ST_RUN);
   assign uplink_role_strap_pin_oe_n = (state_q != RSCL_ST_RUN);
   assign uplink_iface_strap_pins_oe_n = {2{state_q != RSCL_ST_RUN}};
   assign uplink_speed_strap_pin_oe_n = (state_q != RSCL_ST_RUN);
   assign pll_source_strap_pin_oe_n = (state_q != RSCL_ST_RUN);
   assign serial_data_out_o = sdo_q;
   assign serial_data_out_oe_n = sdo_oe_n_q;
   assign serial_data_io_oe_n = !(cfg_q.mdio_mode && state_q == RSCL_ST_RUN && mdio_drive);

   // Configuration outputs
   assign cfg = cfg_q;
   assign cfg_valid = (state_q == RSCL_ST_RUN);
   assign ref_clock_output_en = cfg_q.refclk_en && state_q == RSCL_ST_RUN;
   assign rmii_clk_internal = rmii_int_q;
   assign uplink_rx_clock_pin_oe_n = !((cfg_q.iface == RSCL_IF_MII && !cfg_q.mac_role)
      || (cfg_q.iface == RSCL_IF_RMII && rmii_int_q)
      || cfg_q.iface == RSCL_IF_GMII || cfg_q.iface == RSCL_IF_RGMII);
   assign uplink_tx_clock_pin_oe_n = !(cfg_q.iface == RSCL_IF_MII && !cfg_q.mac_role);
   assign crs_col_oe_n = !((cfg_q.iface == RSCL_IF_MII || cfg_q.iface == RSCL_IF_GMII)
      && !cfg_q.mac_role);
   assign pll_use_ext_clock = cfg_q.iface == RSCL_IF_RMII && !rmii_int_q && !cfg_q.pll_crystal;
   assign uplink_gig_mac_1g = gig_q && (cfg_q.iface == RSCL_IF_GMII || cfg_q.iface == RSCL_IF_RGMII);

   // Checks
   sequence s_capture;
      state_q == RSCL_ST_SAMPLE && cap_cnt_q == 2'h2;
   endsequence

   a_strap_capture: assert property (@(posedge ref_clk) disable iff (rst)
      s_capture |=> cfg_q.refclk_en == $past(strap_sync_q[0]) && cfg_q.iface == $past(strap_sync_q[3:2]))
      else $error("strap not captured");
   a_pins_input_reset: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> refclk_enable_strap_pin_oe_n [*3] ##1 !refclk_enable_strap_pin_oe_n)
      else $error("strap pin direction wrong");
   a_led_drive: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == RSCL_ST_RUN ##1 state_q == RSCL_ST_RUN |-> led_q[0] == !led_pick(
         $past(led_src_a[0]), $past(led_src_b[0]), $past(led_mode)))
      else $error("led wrong");
   a_refclk_enable: assert property (@(posedge ref_clk) disable iff (rst)
      s_capture ##1 1'b1 |-> ref_clock_output_en == $past(strap_sync_q[0]))
      else $error("refclk enable wrong");
   a_phy_outputs: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_valid && cfg_q.iface == RSCL_IF_MII && !cfg_q.mac_role |-> !crs_col_oe_n && !uplink_tx_clock_pin_oe_n
      && !uplink_rx_clock_pin_oe_n)
      else $error("phy role pins not driven");
   a_sw_rmii_clk: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_valid && sw_rmii_clk_wr |=> rmii_clk_internal == $past(sw_rmii_clk_internal))
      else $error("rmii override lost");
   a_sw_speed: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_valid && sw_speed_wr ##1 cfg_q.iface == RSCL_IF_GMII |-> uplink_gig_mac_1g == $past(sw_speed_gig))
      else $error("speed override lost");
   a_cs_float: assert property (@(posedge ref_clk) disable iff (rst)
      cs_sync_q |=> serial_data_out_oe_n)
      else $error("serial out driven while deselected");
   a_cfg_hold: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_valid ##1 cfg_valid |-> $stable(cfg_q))
      else $error("configuration changed");

endmodule // rscl_latch

// ==== tb/rscl_board.sv ====
// Board strap resistors and pad resolution for the strap latch
`timescale 1ns/1ns
module rscl_board (
   // Strap resistor levels
   input wire logic [6:0] strap,
   // Device pad drive, enable low drives
   input wire logic [6:0] pad_o,
   input wire logic [6:0] pad_oe_n,
   // Resolved pad levels
   output logic [6:0] pad
);
   // Every strap has an explicit resistor, serial one included
   // No serial clock reaches this block, host rate is kept elsewhere
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pad[i] = pad_oe_n[i] ? strap[i] : pad_o[i];
      end
   end
endmodule // rscl_board

// ==== tb/tb.sv ====
// Self-checking bench for the strap latch
`timescale 1ns/1ns
module tb import rscl_pkg::*;;
   typedef struct packed {logic [2:0] kind; logic [7:0] v;} rscl_note_s;
   logic ref_clk, rst, serial_chip_select_n, spi_q_data, mdio_drive, cfg_valid, ref_clock_output_en;
   logic sw_rmii_clk_wr, sw_rmii_clk_internal, sw_speed_wr, sw_speed_gig, rmii_clk_internal;
   logic uplink_rx_clock_pin_oe_n, uplink_tx_clock_pin_oe_n, crs_col_oe_n, pll_use_ext_clock;
   logic uplink_gig_mac_1g, serial_data_io_oe_n;
   logic [5:0] led_src_a, led_src_b;
   logic [1:0] led_mode;
   logic [6:0] strap, pad, po, poe;
   logic [31:0] seed = 32'hC1187E53;
   rscl_cfg_s cfg;
   rscl_note_s notes[$];
   rscl_note_s n;
   int n_mismatch = 0;
   int total_checks = 0;
   rscl_board board (.strap(strap), .pad_o(po), .pad_oe_n(poe), .pad(pad));
   rscl_latch DUT (.ref_clk, .rst, .refclk_enable_strap_pin_i(pad[0]), .refclk_enable_strap_pin_o(po[0]),
      .refclk_enable_strap_pin_oe_n(poe[0]), .uplink_role_strap_pin_i(pad[1]), .uplink_role_strap_pin_o(po[1]),
      .uplink_role_strap_pin_oe_n(poe[1]), .uplink_iface_strap_pins_i(pad[3:2]),
      .uplink_iface_strap_pins_o(po[3:2]), .uplink_iface_strap_pins_oe_n(poe[3:2]),
      .uplink_speed_strap_pin_i(pad[4]), .uplink_speed_strap_pin_o(po[4]), .uplink_speed_strap_pin_oe_n(poe[4]),
      .pll_source_strap_pin_i(pad[5]), .pll_source_strap_pin_o(po[5]), .pll_source_strap_pin_oe_n(poe[5]),
      .serial_data_out_i(pad[6]), .serial_data_out_o(po[6]), .serial_data_out_oe_n(poe[6]),
      .serial_chip_select_n, .serial_data_io_oe_n, .led_src_a, .led_src_b, .led_mode, .spi_q_data,
      .mdio_drive, .sw_rmii_clk_wr, .sw_rmii_clk_internal, .sw_speed_wr, .sw_speed_gig, .cfg, .cfg_valid,
      .ref_clock_output_en, .rmii_clk_internal, .uplink_rx_clock_pin_oe_n, .uplink_tx_clock_pin_oe_n,
      .crs_col_oe_n, .pll_use_ext_clock, .uplink_gig_mac_1g);
   always #5 ref_clk = ~ref_clk;
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 8; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      end
      return seed;
   endfunction
   function automatic logic [7:0] exp_misc(input logic [6:0] s, input logic ri, input logic g);
      logic ph;
      logic [1:0] f;
      ph = !s[1];
      f = s[3:2];
      return {1'b1, s[0], ri, !((f == RSCL_IF_MII && ph) || (f == RSCL_IF_RMII && ri) || f[1]),
         !(f == RSCL_IF_MII && ph), !(ph && !f[0]), f == RSCL_IF_RMII && !s[5] && !ri, g && f[1]};
   endfunction
   function automatic logic [7:0] probe(input logic [2:0] k);
      case (k)
         3'h1: return {1'b0, poe};
         3'h2: return {2'h0, po[5:0]};
         3'h3: return {cfg_valid, ref_clock_output_en, rmii_clk_internal, uplink_rx_clock_pin_oe_n,
            uplink_tx_clock_pin_oe_n, crs_col_oe_n, pll_use_ext_clock, uplink_gig_mac_1g};
         3'h4: return {6'h00, poe[6], serial_data_io_oe_n};
         default: return {7'h00, po[6]};
      endcase
   endfunction
   task automatic note(input logic [2:0] k, input logic [7:0] v);
      notes.push_back('{k, v});
   endtask
   task automatic cmp_cfg(input rscl_cfg_s e, input rscl_cfg_s s);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD cfg expected %h seen %h", e, s);
      end
   endtask
   task automatic cmp_bits(input logic [2:0] k, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD output group %0d expected %h seen %h", k, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Every queued note, oldest first, against what the outputs show
   always @(negedge ref_clk) begin
      while (notes.size() > 0) begin
         n = notes.pop_front();
         if (n.kind == 3'h0) cmp_cfg(n.v[6:0], cfg);
         else cmp_bits(n.kind, n.v, probe(n.kind));
      end
   end
   initial begin
      logic [6:0] s;
      logic [6:0] ce;
      logic [5:0] sel;
      logic [31:0] r;
      int k;
      ref_clk = 1'b0;
      rst = 1'b1;
      strap = 7'h00;
      serial_chip_select_n = 1'b1;
      {spi_q_data, mdio_drive, sw_rmii_clk_wr, sw_rmii_clk_internal, sw_speed_wr, sw_speed_gig} = 6'h00;
      {led_src_a, led_src_b, led_mode} = 14'h0000;
      for (int i = 0; i < 8; i++) begin
         s = 7'(rnd());
         s[3:2] = i[1:0];
         s[1] = i[2];
         s[6] = i[1] ^ i[2];
         ce = {s[0], s[1], s[3], s[2], s[4], s[5], s[6]};
         rst <= 1'b1;
         strap <= s;
         serial_chip_select_n <= 1'b1;
         sw_rmii_clk_wr <= 1'b1;
         sw_rmii_clk_internal <= ~s[1];
         sw_speed_wr <= 1'b1;
         sw_speed_gig <= ~s[4];
         repeat (8) @(posedge ref_clk);
         note(3'h0, 8'h7E);
         note(3'h1, 8'h7F);
         sw_rmii_clk_wr <= 1'b0;
         sw_speed_wr <= 1'b0;
         rst <= 1'b0;
         for (k = 0; k < 10 && cfg_valid !== 1'b1; k++) @(negedge ref_clk);
         if (k == 10) begin
            n_mismatch++;
            print_verdict();
         end
         repeat (2) @(posedge ref_clk);
         note(3'h0, {1'b0, ce});
         note(3'h1, 8'h40);
         note(3'h3, exp_misc(s, s[1], s[4]));
         for (int m = 0; m < 4; m++) begin
            r = rnd();
            led_src_a <= r[5:0];
            led_src_b <= r[11:6];
            led_mode <= m[1:0];
            sel = m == 0 ? r[5:0] : m == 1 ? r[11:6] : m == 2 ? r[5:0] & r[11:6] : r[5:0] | r[11:6];
            repeat (2) @(posedge ref_clk);
            note(3'h2, {2'h0, ~sel});
         end
         note(3'h0, {1'b0, ce});
         r = rnd();
         serial_chip_select_n <= 1'b0;
         spi_q_data <= r[0];
         mdio_drive <= r[1];
         repeat (4) @(posedge ref_clk);
         note(3'h4, s[6] ? {7'h01, ~r[1]} : 8'h01);
         if (!s[6]) note(3'h5, {7'h00, r[0]});
         serial_chip_select_n <= 1'b1;
         repeat (4) @(posedge ref_clk);
         note(3'h4, {7'h01, s[6] ? ~r[1] : 1'b1});
         sw_rmii_clk_wr <= 1'b1;
         sw_rmii_clk_internal <= r[2];
         sw_speed_wr <= 1'b1;
         sw_speed_gig <= r[3];
         @(posedge ref_clk);
         sw_rmii_clk_wr <= 1'b0;
         sw_speed_wr <= 1'b0;
         @(posedge ref_clk);
         note(3'h3, exp_misc(s, r[2], r[3]));
         @(posedge ref_clk);
      end
      repeat (2) @(posedge ref_clk);
      print_verdict();
   end
endmodule // tb
